// file: logic/pcafc_pkg.sv
/*
 Package for the per-port ingress credit handler and transmit arbiter.
 Holds threshold field layout, queue limits, timer codes and the
 arbiter's candidate enumeration. Assumes one port, six channel-and-type
 entries, core clock of 100 MHz.
*/
package pcafc_pkg;
    localparam int NUM_CT = 6;
    localparam int CT_W = 3;
    localparam int THR_W = 32;
    localparam int HDR_LSB = 9;
    localparam int HDR_MSB = 13;
    localparam int HDR_W = 5;
    localparam int PAY_LSB = 0;
    localparam int PAY_MSB = 8;
    localparam int PAY_W = 9;
    localparam int PAY_RSV_W = 3;
    localparam int CNT_W = 12;
    localparam logic [THR_W-1:0] THR_RESET = 32'h0000_0210;
    localparam logic [PAY_W-1:0] MPS128_UNITS = 9'h008;
    localparam logic [PAY_W-1:0] MPS256_UNITS = 9'h010;
    localparam logic [7:0] TMR_WRAP = 8'hff;
    localparam logic [7:0] ACK_LIM_MIN = 8'h02;
    localparam logic [7:0] UFC_LIM_MIN = 8'h02;
    localparam logic [7:0] ACK_LIM_RESET = 8'h00;
    localparam logic [7:0] UFC_LIM_RESET = 8'h00;
    // Entry types by index: 0,3 posted; 1,4 non-posted; 2,5 completion
    localparam logic [NUM_CT-1:0] CT_IS_NP = 6'h12;
    typedef enum logic [3:0] {
        PCAFC_NONE, PCAFC_INITFC, PCAFC_NAK, PCAFC_ACK_HI, PCAFC_UFC_HI,
        PCAFC_RETRY, PCAFC_NEW_TLP, PCAFC_UFC_LO, PCAFC_PM, PCAFC_ACK_LO
    } pcafc_sel_t;
endpackage

// file: logic/pcafc_top.sv
/*
 Credit handler and fixed-priority transmit arbiter for one switch port.
 Assumes the TX path asserts tx_done for one cycle when the granted item
 has left, and upstream logic presents one TLP at a time in order.
*/
`timescale 1ns/10ps
module pcafc_top (
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic sec_bus_reset,
    input wire logic is_downstream,
    // Threshold register port
    input wire logic thr_wr,
    input wire logic [pcafc_pkg::CT_W-1:0] thr_idx,
    input wire logic [pcafc_pkg::THR_W-1:0] thr_wdata,
    output logic [pcafc_pkg::THR_W-1:0] thr_rdata,
    // Serial memory load
    input wire logic eep_wr,
    input wire logic [pcafc_pkg::CT_W-1:0] eep_idx,
    input wire logic [pcafc_pkg::THR_W-1:0] eep_wdata,
    // Timer limits and payload size
    input wire logic [7:0] ack_limit,
    input wire logic [7:0] ufc_limit,
    input wire logic mps_256,
    // Ingress credit events
    input wire logic rx_tlp,
    input wire logic [pcafc_pkg::CT_W-1:0] rx_ct,
    input wire logic [pcafc_pkg::PAY_W-1:0] rx_pay,
    input wire logic rx_relaxed,
    input wire logic free_ev,
    input wire logic [pcafc_pkg::CT_W-1:0] free_ct,
    input wire logic [pcafc_pkg::PAY_W-1:0] free_pay,
    // Transmit candidates
    input wire logic req_initfc,
    input wire logic req_nak,
    input wire logic req_ack,
    input wire logic ack_dup,
    input wire logic req_retry,
    input wire logic req_tlp,
    input wire logic tlp_has_pay,
    input wire logic req_pm,
    input wire logic [pcafc_pkg::PAY_W-1:0] partner_pay_credit,
    input wire logic tx_done,
    // Grant and updateFC content
    output logic [3:0] tx_grant,
    output logic tx_busy,
    output logic [pcafc_pkg::CT_W-1:0] ufc_ct,
    output logic [pcafc_pkg::HDR_W-1:0] ufc_hdr,
    output logic [pcafc_pkg::PAY_W-1:0] ufc_pay,
    output logic rx_order_strict
);
    import pcafc_pkg::*;

    logic [THR_W-1:0] thr_reg [NUM_CT];
    logic [THR_W-1:0] act_reg [NUM_CT];
    logic [CNT_W-1:0] debt_hdr_reg [NUM_CT];
    logic [CNT_W-1:0] debt_pay_reg [NUM_CT];
    logic [NUM_CT-1:0] ufc_pend_reg;
    logic [7:0] ufc_tmr_reg [NUM_CT];
    logic [7:0] ack_tmr_reg;
    logic sbr_q_reg;
    pcafc_sel_t sel_reg;
    pcafc_sel_t sel_next;
    logic busy_reg;
    logic [THR_W-1:0] thr_rdata_reg;
    logic [CT_W-1:0] ufc_ct_reg;
    logic [HDR_W-1:0] ufc_hdr_reg;
    logic [PAY_W-1:0] ufc_pay_reg;
    logic [THR_W-1:0] wr_val;
    logic [THR_W-1:0] eep_val;
    logic [CT_W-1:0] pend_ct;
    logic pend_any;
    logic pend_hi;
    logic pay_ok;
    logic [7:0] ack_eff;
    logic [7:0] ufc_eff;
    logic sbr_fall;

    // Clear reserved low payload bits for posted and completion entries
    function automatic logic [THR_W-1:0] clean_thr(
        input logic [THR_W-1:0] v, input logic [CT_W-1:0] idx);
        logic [THR_W-1:0] r;
        r = '0;
        r[HDR_MSB:HDR_LSB] = v[HDR_MSB:HDR_LSB];
        r[PAY_MSB:PAY_LSB] = v[PAY_MSB:PAY_LSB];
        if (!CT_IS_NP[idx]) begin
            r[PAY_RSV_W-1:0] = '0;
        end
        return r;
    endfunction

    // Limit codes below the minimum stand for the longest wait
    function automatic logic [7:0] eff_limit(
        input logic [7:0] v, input logic [7:0] minv);
        return (v < minv) ? TMR_WRAP : v;
    endfunction

    assign wr_val = clean_thr(thr_wdata, thr_idx);
    assign eep_val = clean_thr(eep_wdata, eep_idx);
    assign ack_eff = eff_limit(ack_limit, ACK_LIM_MIN);
    assign ufc_eff = eff_limit(ufc_limit, UFC_LIM_MIN);
    assign sbr_fall = sbr_q_reg && !sec_bus_reset;
    // One max payload of partner credit before any payload TLP
    assign pay_ok = !tlp_has_pay ||
        (partner_pay_credit >= (mps_256 ? MPS256_UNITS : MPS128_UNITS));

    // Programmed thresholds; primary reset restores the initial value
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CT; i++) begin
            if (rst) begin
                thr_reg[i] <= THR_RESET;
            end else if (thr_wr && thr_idx == CT_W'(i)) begin
                thr_reg[i] <= wr_val;
            end else if (eep_wr && eep_idx == CT_W'(i)) begin
                thr_reg[i] <= eep_val;
            end
        end
    end

    // Advertised thresholds: upstream follows writes, downstream waits
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CT; i++) begin
            if (rst) begin
                act_reg[i] <= THR_RESET;
            end else if (eep_wr && eep_idx == CT_W'(i)) begin
                act_reg[i] <= eep_val;
            end else if (is_downstream) begin
                if (sbr_fall) begin
                    act_reg[i] <= thr_reg[i];
                end
            end else if (thr_wr && thr_idx == CT_W'(i)) begin
                act_reg[i] <= wr_val;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sbr_q_reg <= 1'b0;
        end else begin
            sbr_q_reg <= sec_bus_reset;
        end
    end

    // Credit debt: lowered threshold must be consumed before new credit
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CT; i++) begin
            if (rst || (is_downstream && sec_bus_reset)) begin
                debt_hdr_reg[i] <= '0;
                debt_pay_reg[i] <= '0;
            end else if (!is_downstream && thr_wr && thr_idx == CT_W'(i)) begin
                if (wr_val[HDR_MSB:HDR_LSB] < act_reg[i][HDR_MSB:HDR_LSB]) begin
                    debt_hdr_reg[i] <= debt_hdr_reg[i] + CNT_W'(
                        act_reg[i][HDR_MSB:HDR_LSB] -
                        wr_val[HDR_MSB:HDR_LSB]);
                end
                if (wr_val[PAY_MSB:PAY_LSB] < act_reg[i][PAY_MSB:PAY_LSB]) begin
                    debt_pay_reg[i] <= debt_pay_reg[i] + CNT_W'(
                        act_reg[i][PAY_MSB:PAY_LSB] -
                        wr_val[PAY_MSB:PAY_LSB]);
                end
            end else if (free_ev && free_ct == CT_W'(i)) begin
                // Freed space pays the debt first, nothing is returned
                debt_hdr_reg[i] <= (debt_hdr_reg[i] != '0) ?
                    debt_hdr_reg[i] - CNT_W'(1) : '0;
                debt_pay_reg[i] <= (debt_pay_reg[i] > CNT_W'(free_pay)) ?
                    debt_pay_reg[i] - CNT_W'(free_pay) : '0;
            end
        end
    end

    // Pending updateFC per entry; a new event wins over the send clear
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CT; i++) begin
            if (rst) begin
                ufc_pend_reg[i] <= 1'b0;
            end else if (thr_wr && !is_downstream && thr_idx == CT_W'(i) &&
                         (wr_val[HDR_MSB:HDR_LSB] >
                          act_reg[i][HDR_MSB:HDR_LSB] ||
                          wr_val[PAY_MSB:PAY_LSB] >
                          act_reg[i][PAY_MSB:PAY_LSB])) begin
                ufc_pend_reg[i] <= 1'b1;
            end else if (free_ev && free_ct == CT_W'(i) &&
                         debt_hdr_reg[i] == '0 &&
                         debt_pay_reg[i] <= CNT_W'(free_pay)) begin
                ufc_pend_reg[i] <= 1'b1;
            end else if (sbr_fall && is_downstream) begin
                ufc_pend_reg[i] <= 1'b1;
            end else if (busy_reg && tx_done && ufc_ct_reg == CT_W'(i) &&
                         (sel_reg == PCAFC_UFC_HI ||
                          sel_reg == PCAFC_UFC_LO)) begin
                ufc_pend_reg[i] <= 1'b0;
            end
        end
    end

    // Per-entry pending timers sharing one limit
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CT; i++) begin
            if (rst || !ufc_pend_reg[i]) begin
                ufc_tmr_reg[i] <= '0;
            end else if (ufc_tmr_reg[i] < ufc_eff) begin
                ufc_tmr_reg[i] <= ufc_tmr_reg[i] + 8'h01;
            end
        end
    end

    // ACK latency timer runs while an ACK waits
    always_ff @(posedge clk) begin
        if (rst || !req_ack) begin
            ack_tmr_reg <= '0;
        end else if (ack_tmr_reg < ack_eff) begin
            ack_tmr_reg <= ack_tmr_reg + 8'h01;
        end
    end

    // Lowest pending entry, and whether any entry has timed out
    always_comb begin
        pend_ct = '0;
        pend_any = 1'b0;
        pend_hi = 1'b0;
        for (int i = NUM_CT - 1; i >= 0; i--) begin
            if (ufc_pend_reg[i]) begin
                pend_ct = CT_W'(i);
                pend_any = 1'b1;
                if (ufc_tmr_reg[i] >= ufc_eff) begin
                    pend_hi = 1'b1;
                end
            end
        end
    end

    // Fixed priority pick; a waiting ACK can go low when the link is idle
    always_comb begin
        if (req_initfc) begin
            sel_next = PCAFC_INITFC;
        end else if (req_nak) begin
            sel_next = PCAFC_NAK;
        end else if (req_ack && (ack_dup || ack_tmr_reg >= ack_eff)) begin
            sel_next = PCAFC_ACK_HI;
        end else if (pend_hi) begin
            sel_next = PCAFC_UFC_HI;
        end else if (req_retry) begin
            sel_next = PCAFC_RETRY;
        end else if (req_tlp && pay_ok) begin
            sel_next = PCAFC_NEW_TLP;
        end else if (pend_any) begin
            sel_next = PCAFC_UFC_LO;
        end else if (req_pm) begin
            sel_next = PCAFC_PM;
        end else if (req_ack) begin
            sel_next = PCAFC_ACK_LO;
        end else begin
            sel_next = PCAFC_NONE;
        end
    end

    // Grant holds until the item finishes; no preemption
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            sel_reg <= PCAFC_NONE;
        end else if (busy_reg) begin
            if (tx_done) begin
                busy_reg <= 1'b0;
                sel_reg <= PCAFC_NONE;
            end
        end else if (sel_next != PCAFC_NONE) begin
            busy_reg <= 1'b1;
            sel_reg <= sel_next;
        end
    end

    // UpdateFC content latched with the grant, stable while sent
    always_ff @(posedge clk) begin
        if (rst) begin
            ufc_ct_reg <= '0;
            ufc_hdr_reg <= '0;
            ufc_pay_reg <= '0;
        end else if (!busy_reg && (sel_next == PCAFC_UFC_HI ||
                                   sel_next == PCAFC_UFC_LO)) begin
            ufc_ct_reg <= pend_ct;
            ufc_hdr_reg <= act_reg[pend_ct][HDR_MSB:HDR_LSB];
            ufc_pay_reg <= act_reg[pend_ct][PAY_MSB:PAY_LSB];
        end
    end

    // Register readback of the programmed value
    always_ff @(posedge clk) begin
        if (rst) begin
            thr_rdata_reg <= THR_RESET;
        end else begin
            // Unused indices read zero rather than an undefined entry
            thr_rdata_reg <= (thr_idx < CT_W'(NUM_CT)) ? thr_reg[thr_idx] : '0;
        end
    end

    // Relaxed ordering bit has no effect; order stays strict
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_order_strict <= 1'b1;
        end else begin
            rx_order_strict <= 1'b1 | (rx_tlp & rx_relaxed);
        end
    end

    assign thr_rdata = thr_rdata_reg;
    assign tx_grant = sel_reg;
    assign tx_busy = busy_reg;
    assign ufc_ct = ufc_ct_reg;
    assign ufc_hdr = ufc_hdr_reg;
    assign ufc_pay = ufc_pay_reg;

endmodule // pcafc_top

// file: tb/pcafc_assertions.sv
/*
 Checker for the credit handler and transmit arbiter.
 Sees only the top module ports; bound in below the module.
*/
`timescale 1ns/10ps
module pcafc_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Candidates and partner state
    input wire logic req_initfc,
    input wire logic req_nak,
    input wire logic req_ack,
    input wire logic ack_dup,
    input wire logic req_retry,
    input wire logic req_tlp,
    input wire logic tlp_has_pay,
    input wire logic mps_256,
    input wire logic [pcafc_pkg::PAY_W-1:0] partner_pay_credit,
    input wire logic tx_done,
    input wire logic rx_tlp,
    // Results
    input wire logic [3:0] tx_grant,
    input wire logic tx_busy,
    input wire logic [pcafc_pkg::THR_W-1:0] thr_rdata,
    input wire logic rx_order_strict
);
    import pcafc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Arbiter may pick only while no item is on the wire
    wire arb_free = !tx_busy;
    sequence s_held; tx_busy && !tx_done; endsequence
    sequence s_ends; tx_busy && tx_done; endsequence
    sequence s_idle; !tx_busy && tx_grant == 4'h0; endsequence
    AST_NO_PREEMPT: assert property (
        s_held |=> tx_busy && $stable(tx_grant))
        else $error("grant moved mid item");
    AST_DONE_IDLE: assert property (s_ends |=> s_idle)
        else $error("grant stayed after done");
    AST_INITFC_TOP: assert property (
        arb_free && req_initfc |=> tx_grant == PCAFC_INITFC)
        else $error("initfc not first");
    AST_NAK_NEXT: assert property (
        arb_free && !req_initfc && req_nak |=> tx_grant == PCAFC_NAK)
        else $error("nak not second");
    AST_ACK_DUP: assert property (
        arb_free && !req_initfc && !req_nak && req_ack && ack_dup
        |=> tx_grant == PCAFC_ACK_HI)
        else $error("urgent ack not third");
    AST_RETRY_AHEAD: assert property (
        arb_free && req_retry && !req_initfc && !req_nak
        && !(req_ack && ack_dup)
        |=> tx_grant inside {PCAFC_ACK_HI, PCAFC_UFC_HI, PCAFC_RETRY})
        else $error("replay lost to lower item");
    AST_PAY_HOLD: assert property (
        arb_free && req_tlp && tlp_has_pay
        && partner_pay_credit < (mps_256 ? MPS256_UNITS : MPS128_UNITS)
        |=> tx_grant != PCAFC_NEW_TLP)
        else $error("payload sent without credit");
    AST_STRICT: assert property (rx_tlp |=> rx_order_strict)
        else $error("order not strict");
    AST_RESET_THR: assert property (
        $fell(rst) |-> thr_rdata == THR_RESET && tx_grant == 4'h0)
        else $error("threshold not at reset value");
endmodule // pcafc_assertions

bind pcafc_top pcafc_assertions i_chk (.clk, .rst, .req_initfc, .req_nak,
    .req_ack, .ack_dup, .req_retry, .req_tlp, .tlp_has_pay, .mps_256,
    .partner_pay_credit, .tx_done, .rx_tlp, .tx_grant, .tx_busy, .thr_rdata,
    .rx_order_strict);

// file: tb/pcafc_link_partner.sv
/*
 Link partner and transmit path model: sends each granted item.
 Assumes the arbiter holds tx_busy until it sees tx_done.
*/
`timescale 1ns/10ps
module pcafc_link_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench controls
    input wire logic slow,
    input wire logic [pcafc_pkg::PAY_W-1:0] credit_set,
    // Device side
    input wire logic tx_busy,
    output logic tx_done,
    output logic [pcafc_pkg::PAY_W-1:0] partner_pay_credit
);
    import pcafc_pkg::*;
    int cnt;
    // Advertised payload credit; the bench may go below one max payload
    assign partner_pay_credit = credit_set;
    // Item takes two or six cycles; done stands one cycle only
    always_ff @(posedge clk) begin
        if (rst || !tx_busy || tx_done) begin
            cnt <= 0;
            tx_done <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            tx_done <= (cnt == (slow ? 5 : 1));
        end
    end
endmodule // pcafc_link_partner

// file: tb/pcafc_top_tb_top.sv
/*
 Bench for the credit handler and arbiter: model, stimulus, verdict.
 Assumes the link partner model answers every grant.
*/
`timescale 1ns/10ps
module pcafc_top_tb_top;
    import pcafc_pkg::*;
    logic clk, rst, sec_bus_reset, is_downstream, thr_wr, eep_wr, mps_256;
    logic [2:0] thr_idx, eep_idx, rx_ct, free_ct, ufc_ct;
    logic [31:0] thr_wdata, eep_wdata, thr_rdata;
    logic [7:0] ack_limit, ufc_limit, reqs;
    logic rx_tlp, rx_relaxed, free_ev, tx_done, tx_busy, slow;
    logic [8:0] rx_pay, free_pay, credit_set, partner_pay_credit, ufc_pay;
    logic req_initfc, req_nak, req_ack, ack_dup, req_retry, req_tlp;
    logic tlp_has_pay, req_pm, rx_order_strict;
    logic [3:0] tx_grant;
    logic [4:0] ufc_hdr;
    logic [20:0] ufc_seen;
    logic [31:0] rv;
    int n_errors, samples_checked, seed, i;
    int thr_m [6];
    assign {req_pm, tlp_has_pay, req_tlp, req_retry, ack_dup, req_ack,
        req_nak, req_initfc} = reqs;
    // Grant and updateFC content seen together
    assign ufc_seen = {tx_grant, ufc_ct, ufc_hdr, ufc_pay};
    pcafc_top i_dut (.clk, .rst, .sec_bus_reset, .is_downstream, .thr_wr,
        .thr_idx, .thr_wdata, .thr_rdata, .eep_wr, .eep_idx, .eep_wdata,
        .ack_limit, .ufc_limit, .mps_256, .rx_tlp, .rx_ct, .rx_pay,
        .rx_relaxed, .free_ev, .free_ct, .free_pay, .req_initfc, .req_nak,
        .req_ack, .ack_dup, .req_retry, .req_tlp, .tlp_has_pay, .req_pm,
        .partner_pay_credit, .tx_done, .tx_grant, .tx_busy, .ufc_ct,
        .ufc_hdr, .ufc_pay, .rx_order_strict);
    pcafc_link_partner i_lp (.clk, .rst, .slow, .credit_set, .tx_busy,
        .tx_done, .partner_pay_credit);
    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait for busy (0) or done (1); a hang ends the run
    task wait_on(input int on_done);
        int k;
        for (k = 0; k < 600; k++) begin
            @(posedge clk);
            #1;
            if ((on_done ? tx_done : tx_busy) === 1'b1)
                return;
        end
        n_errors++;
        wrap_up();
    endtask
    task do_reset;
        int j;
        @(posedge clk);
        rst <= 1'b1;
        tick(16);
        rst <= 1'b0;
        for (j = 0; j < 6; j++)
            thr_m[j] = 32'h210;
    endtask
    // Model keeps header 13:9 and payload 8:0, P/Cpl low bits cleared
    task wr(input int idx, input logic [31:0] v, input logic eep);
        @(posedge clk);
        {thr_wr, eep_wr} <= {~eep, eep};
        {thr_idx, eep_idx} <= {2{idx[2:0]}};
        {thr_wdata, eep_wdata} <= {v, v};
        thr_m[idx] = v & ((idx % 3 == 1) ? 32'h3fff : 32'h3ff8);
        @(posedge clk);
        {thr_wr, eep_wr} <= 2'b00;
    endtask
    task rd(input int idx);
        @(posedge clk);
        thr_idx <= idx[2:0];
        tick(2);
        #1;
        chk(thr_rdata, thr_m[idx]);
    endtask
    // One arbitration round against the fixed priority list
    task arb(input logic [7:0] r, input logic [8:0] cr, input logic m);
        int e;
        e = r[0] ? 1 : r[1] ? 2 : (r[2] && r[3]) ? 3 : r[4] ? 5 :
            (r[5] && (!r[6] || cr >= (m ? 16 : 8))) ? 6 :
            r[7] ? 8 : r[2] ? 9 : 0;
        @(posedge clk);
        {reqs, credit_set, mps_256, slow} <= {r, cr, m, r[3]};
        if (e == 0) begin
            tick(4);
            #1;
            chk(tx_grant, 0);
        end else begin
            wait_on(0);
            chk(tx_grant, e);
            @(posedge clk);
            reqs[0] <= 1'b1;
            wait_on(1);
            chk(tx_grant, e);
        end
        @(posedge clk);
        reqs <= 8'h00;
    endtask
    // One freed-space event on entry 1: one header plus p payload units
    task free1(input logic [8:0] p);
        @(posedge clk);
        {free_ev, free_ct, free_pay} <= {1'b1, 3'h1, p};
        @(posedge clk);
        free_ev <= 1'b0;
    endtask
    initial begin
        {sec_bus_reset, thr_wr, eep_wr, thr_idx, eep_idx, rx_ct, free_ct,
            thr_wdata, eep_wdata, ack_limit, ufc_limit, mps_256, rx_tlp,
            rx_relaxed, free_ev, slow, rx_pay, free_pay, credit_set} = '0;
        {rst, is_downstream, reqs, n_errors, samples_checked} = '0;
        rst = 1'b1;
        is_downstream = 1'b1;
        seed = 32'h02b5;
        do_reset();
        // Downstream writes are stored but not yet advertised
        // Random header 0..3 and payload 16..127 keep the software limits
        for (i = 0; i < 18; i++) begin
            rv = ($random(seed) & 32'hffff_c67f) | 32'h10;
            wr(i % 6, (i < 6) ? 32'h210 : rv, 1'b0);
            rd(i % 6);
        end
        wr(2, 32'h0a5f, 1'b1);
        rd(2);
        tick(100);
        wr(4, 32'h1c40, 1'b0);
        tick(20);
        chk(tx_busy, 0);
        @(posedge clk);
        sec_bus_reset <= 1'b1;
        tick(2);
        sec_bus_reset <= 1'b0;
        wait_on(0);
        chk(tx_grant, 7);
        tick(150);
        arb(8'h80, 9'h000, 1'b0);
        arb(8'h04, 9'h000, 1'b0);
        arb(8'h48, 9'h000, 1'b0);
        arb(8'h60, 9'h007, 1'b0);
        arb(8'h60, 9'h008, 1'b0);
        arb(8'h60, 9'h00f, 1'b1);
        arb(8'h60, 9'h010, 1'b1);
        for (i = 0; i < 40; i++)
            arb(8'($random(seed)), 9'($random(seed) & 31), 1'($random(seed)));
        // Raise while an item is on the wire; new TLP beats plain updateFC
        @(posedge clk);
        is_downstream <= 1'b0;
        do_reset();
        @(posedge clk);
        {reqs[7], slow} <= 2'b11;
        wait_on(0);
        wr(1, 32'h0a14, 1'b0);
        reqs[5] <= 1'b1;
        wait_on(1);
        @(posedge clk);
        reqs[7] <= 1'b0;
        wait_on(0);
        chk(tx_grant, 6);
        wait_on(1);
        @(posedge clk);
        reqs[5] <= 1'b0;
        wait_on(0);
        chk(ufc_seen, {4'h7, 3'h1, 5'h05, 9'h014});
        wait_on(1);
        // Received and freed space comes back only by updateFC
        @(posedge clk);
        {rx_tlp, rx_ct, rx_pay, rx_relaxed} <= {1'b1, 3'h1, 9'h004, 1'b1};
        @(posedge clk);
        rx_tlp <= 1'b0;
        {free_ev, free_ct, free_pay} <= {1'b1, 3'h1, 9'h004};
        @(posedge clk);
        free_ev <= 1'b0;
        wait_on(0);
        chk({tx_grant, ufc_ct}, {4'h7, 3'h1});
        chk(rx_order_strict, 1);
        wait_on(1);
        // Lowered threshold: no credit back until the difference is used
        wr(1, 32'h0604, 1'b0);
        free1(9'h008);
        free1(9'h008);
        tick(8);
        chk(tx_busy, 0);
        free1(9'h008);
        wait_on(0);
        chk(ufc_seen, {4'h7, 3'h1, 5'h03, 9'h004});
        wait_on(1);
        // Timed-out updateFC overtakes replays within a few items
        @(posedge clk);
        {reqs, ufc_limit} <= {8'h10, 8'h10};
        wr(0, 32'h0420, 1'b0);
        wait_on(0);
        for (i = 0; i < 6 && tx_grant == 4'h5; i++) begin
            wait_on(1);
            wait_on(0);
        end
        chk(ufc_seen, {4'h4, 3'h0, 5'h02, 9'h020});
        wait_on(1);
        // A waiting ACK goes below a new TLP until its timer runs out
        @(posedge clk);
        {reqs, ack_limit} <= {8'h24, 8'h04};
        wait_on(0);
        chk(tx_grant, 6);
        wait_on(1);
        wait_on(0);
        chk(tx_grant, 3);
        wait_on(1);
        @(posedge clk);
        reqs <= 8'h00;
        wr(3, 32'h2a20, 1'b0);
        do_reset();
        for (i = 0; i < 6; i++)
            rd(i);
        wrap_up();
    end
endmodule // pcafc_top_tb_top
